// File: inc/seqsel_pkg.sv
package seqsel_pkg;
  localparam int ADDR_W = 12;
  localparam int SEL_W = 3;
  localparam int SLOT_W = 3;
  localparam int SLOT_COUNT = 8;
  localparam int CNT_W = 4;
  localparam logic [ADDR_W-1:0] OFS_INPUT_SELECT = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_SEQ_CONTROL = 12'h044;
  localparam logic [ADDR_W-1:0] OFS_SEQ_STATUS = 12'h048;
  localparam logic [31:0] INPUT_SELECT_RST = 32'h0000_0000;
  localparam logic [31:0] INPUT_SELECT_MASK = 32'h7777_7777;
  localparam logic [31:0] SEQ_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] SEQ_CONTROL_MASK = 32'h0000_07FF;
  localparam int SLOT1_SEL_LSB = 0;
  localparam int SLOT2_SEL_LSB = 4;
  localparam int SLOT3_SEL_LSB = 8;
  localparam int SLOT4_SEL_LSB = 12;
  localparam int SLOT5_SEL_LSB = 16;
  localparam int SLOT6_SEL_LSB = 20;
  localparam int SLOT7_SEL_LSB = 24;
  localparam int SLOT8_SEL_LSB = 28;
  localparam int CTRL_TEMP_LSB = 0;
  localparam int CTRL_LAST_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SLOT_LSB = 4;
  localparam int STAT_STATE_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MUX_SETTLE_NS = 50;
  localparam int MUX_SETTLE_CYC =
    (MUX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETTLE = 4'h2,
    ST_START = 4'h4,
    ST_WAIT = 4'h8
  } seq_state_t;

  function automatic logic word_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
    return addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb,
                                             input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction
endpackage

// File: inc/slot_if.sv
`timescale 1ns/10ps
interface slot_if;
  import seqsel_pkg::*;
  logic [31:0] select_word;
  logic [SLOT_COUNT-1:0] temp_choice;
  logic [SLOT_W-1:0] slot;
  logic [SEL_W-1:0] pin_sel;
  logic temp_sel;
  modport seq (output select_word, temp_choice, slot,
               input pin_sel, temp_sel);
  modport mux (input select_word, temp_choice, slot,
               output pin_sel, temp_sel);
endinterface // slot_if

// File: rtl/slot_mux.sv
`timescale 1ns/10ps
module slot_mux
  import seqsel_pkg::*;
(
  slot_if.mux sif
);
  logic [SEL_W-1:0] field;

  always_comb begin
    field = '0;
    unique case (sif.slot)
      3'h0: field = sif.select_word[SLOT1_SEL_LSB +: SEL_W];
      3'h1: field = sif.select_word[SLOT2_SEL_LSB +: SEL_W];
      3'h2: field = sif.select_word[SLOT3_SEL_LSB +: SEL_W];
      3'h3: field = sif.select_word[SLOT4_SEL_LSB +: SEL_W];
      3'h4: field = sif.select_word[SLOT5_SEL_LSB +: SEL_W];
      3'h5: field = sif.select_word[SLOT6_SEL_LSB +: SEL_W];
      3'h6: field = sif.select_word[SLOT7_SEL_LSB +: SEL_W];
      3'h7: field = sif.select_word[SLOT8_SEL_LSB +: SEL_W];
    endcase
  end

  // Field value is the pin index with no translation
  assign sif.pin_sel = field;
  assign sif.temp_sel = sif.temp_choice[sif.slot];
endmodule // slot_mux

// File: rtl/settle_timer.sv
`timescale 1ns/10ps
module settle_timer
  import seqsel_pkg::*;
#(
  parameter int CYCLES = MUX_SETTLE_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  output logic expire_out
);
  logic [CNT_W-1:0] cnt_q;
  logic run_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load_in) begin
      cnt_q <= CNT_W'(CYCLES - 1);
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= CNT_W'(cnt_q - 1'b1);
      end
    end
  end

  // High in the last of CYCLES cycles after a load
  assign expire_out = run_q && (cnt_q == '0);
endmodule // settle_timer

// File: rtl/sequence_input_select.sv
`timescale 1ns/10ps

// Behaviour
// - Eighth slot converts the input chosen by bits 30:28.
// - A select value is used directly as the analog pin index.
// - Seventh slot converts the input chosen by bits 26:24.
// - Sixth slot converts the input chosen by bits 22:20.
// - Fifth slot converts the input chosen by bits 18:16.
// - Fourth slot converts the input chosen by bits 14:12.
// - Third slot converts the input chosen by bits 10:8.
// - Second slot converts the input chosen by bits 6:4.
// - First slot converts the input chosen by bits 2:0.
// - Bits 31,27,23,19,15,11,7,3 read zero and ignore writes.
// - Register serves the first sequencer only, up to eight slots.
// - Select fields are read/write and the register clears to zero on reset.
// - Slot temperature choice bit set converts the sensor instead.
module sequence_input_select
  import seqsel_pkg::*;
#(
  parameter int SETTLE_CYCLES = MUX_SETTLE_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic seq_trigger_in,
  input wire logic sample_done_in,
  output logic [SEL_W-1:0] mux_sel_out,
  output logic temp_sel_out,
  output logic conv_start_out,
  output logic busy_out,
  output logic [SLOT_W-1:0] slot_out
);
  logic aw_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic awready_q;
  logic w_full_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic wr_hit;
  logic rd_take;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [31:0] select_q;
  logic [31:0] ctrl_q;
  logic [SLOT_COUNT-1:0] temp_choice;
  logic [SLOT_W-1:0] last_slot;
  seq_state_t state_q;
  logic [SLOT_W-1:0] slot_q;
  logic [SLOT_W-1:0] slot_pick;
  logic [SEL_W-1:0] mux_sel_q;
  logic temp_sel_q;
  logic conv_start_q;
  logic busy_q;
  logic seq_go;
  logic next_slot;
  logic seq_end;
  logic enter_settle;
  logic settle_done;

  // ********************************************************
  // Write address and data channels
  // ********************************************************
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit = word_hit(awaddr_q, OFS_INPUT_SELECT) ||
                  word_hit(awaddr_q, OFS_SEQ_CONTROL);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
      awready_q <= 1'b0;
    end else if (awvalid_in && awready_q) begin
      aw_full_q <= 1'b1;
      awaddr_q <= awaddr_in;
      awready_q <= 1'b0;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      wready_q <= 1'b0;
    end else if (wvalid_in && wready_q) begin
      w_full_q <= 1'b1;
      wdata_q <= wdata_in;
      wstrb_q <= wstrb_in;
      wready_q <= 1'b0;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // ********************************************************
  // Write response
  // ********************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  // ********************************************************
  // Read channels
  // ********************************************************
  assign rd_take = arvalid_in && arready_q;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (word_hit(araddr_in, OFS_INPUT_SELECT)) begin
      rd_word = select_q & INPUT_SELECT_MASK;
    end else if (word_hit(araddr_in, OFS_SEQ_CONTROL)) begin
      rd_word = ctrl_q & SEQ_CONTROL_MASK;
    end else if (word_hit(araddr_in, OFS_SEQ_STATUS)) begin
      rd_word[STAT_BUSY_BIT] = busy_q;
      rd_word[STAT_SLOT_LSB +: SLOT_W] = slot_q;
      rd_word[STAT_STATE_LSB +: 4] = state_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      arready_q <= 1'b0;
    end else if (rd_take) begin
      arready_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      select_q <= INPUT_SELECT_RST;
    end else if (do_write && word_hit(awaddr_q, OFS_INPUT_SELECT)) begin
      select_q <= merge_strb(select_q, wdata_q, wstrb_q,
                             INPUT_SELECT_MASK);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= SEQ_CONTROL_RST;
    end else if (do_write && word_hit(awaddr_q, OFS_SEQ_CONTROL)) begin
      ctrl_q <= merge_strb(ctrl_q, wdata_q, wstrb_q, SEQ_CONTROL_MASK);
    end
  end

  assign temp_choice = ctrl_q[CTRL_TEMP_LSB +: SLOT_COUNT];
  assign last_slot = ctrl_q[CTRL_LAST_LSB +: SLOT_W];

  // ********************************************************
  // Slot sequencer
  // ********************************************************
  slot_if sif();

  assign seq_go = (state_q == ST_IDLE) && seq_trigger_in;
  assign seq_end = (state_q == ST_WAIT) && sample_done_in &&
                   (slot_q == last_slot);
  assign next_slot = (state_q == ST_WAIT) && sample_done_in &&
                     (slot_q != last_slot);
  assign enter_settle = seq_go || next_slot;
  // Look ahead to the slot about to run so its select is latched early
  assign slot_pick = (state_q == ST_WAIT) ? SLOT_W'(slot_q + 1'b1) : '0;
  assign sif.select_word = select_q;
  assign sif.temp_choice = temp_choice;
  assign sif.slot = slot_pick;

  slot_mux u_mux (
    .sif(sif.mux)
  );

  settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(enter_settle),
    .expire_out(settle_done)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (seq_trigger_in) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_done) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (seq_end) begin
            state_q <= ST_IDLE;
          end else if (next_slot) begin
            state_q <= ST_SETTLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Slot index stops at the programmed last slot, never past eight
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      slot_q <= '0;
    end else if (seq_go) begin
      slot_q <= '0;
    end else if (next_slot) begin
      slot_q <= SLOT_W'(slot_q + 1'b1);
    end
  end

  // Select is frozen from settle entry until the sample completes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mux_sel_q <= '0;
      temp_sel_q <= 1'b0;
    end else if (enter_settle) begin
      mux_sel_q <= sif.pin_sel;
      temp_sel_q <= sif.temp_sel;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= (state_q == ST_SETTLE) && settle_done;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
    end else if (seq_go) begin
      busy_q <= 1'b1;
    end else if (seq_end) begin
      busy_q <= 1'b0;
    end
  end

  assign awready_out = awready_q;
  assign wready_out = wready_q;
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign arready_out = arready_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;
  assign mux_sel_out = mux_sel_q;
  assign temp_sel_out = temp_sel_q;
  assign conv_start_out = conv_start_q;
  assign busy_out = busy_q;
  assign slot_out = slot_q;

  // ********************************************************
  // Assertions
  // ********************************************************
  logic [31:0] select_prev_q;
  logic [31:0] ctrl_prev_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      select_prev_q <= '0;
      ctrl_prev_q <= '0;
    end else begin
      select_prev_q <= select_q;
      ctrl_prev_q <= ctrl_q;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_slot8_field;
    $past(enter_settle) && (slot_q == 3'h7) |->
      mux_sel_q == select_prev_q[SLOT8_SEL_LSB +: SEL_W];
  endproperty
  a_slot8_field: assert property (p_slot8_field)
    else $error("slot 8 select not taken from top field");

  property p_slot1_field;
    $past(enter_settle) && (slot_q == 3'h0) |->
      mux_sel_q == select_prev_q[SLOT1_SEL_LSB +: SEL_W];
  endproperty
  a_slot1_field: assert property (p_slot1_field)
    else $error("slot 1 select not taken from low field");

  property p_any_field;
    $past(enter_settle) |->
      mux_sel_q == 3'(select_prev_q >> {slot_q, 2'h0});
  endproperty
  a_any_field: assert property (p_any_field)
    else $error("pin index differs from slot field");

  property p_temp_choice;
    $past(enter_settle) |->
      temp_sel_q == ctrl_prev_q[CTRL_TEMP_LSB + slot_q];
  endproperty
  a_temp_choice: assert property (p_temp_choice)
    else $error("temperature choice not applied to slot");

  property p_reserved_zero;
    (select_q & ~INPUT_SELECT_MASK) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved select bit is set");

  property p_reset_clear;
    $past(rst_in) |-> select_q == INPUT_SELECT_RST;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("select register not clear after reset");

  property p_full_write;
    do_write && word_hit(awaddr_q, OFS_INPUT_SELECT) &&
      (wstrb_q == 4'hF) |=>
      select_q == ($past(wdata_q) & INPUT_SELECT_MASK);
  endproperty
  a_full_write: assert property (p_full_write)
    else $error("full write to select register lost");

  property p_hold_sample;
    (state_q == ST_START) || (state_q == ST_WAIT) |->
      $stable(mux_sel_q) && $stable(temp_sel_q);
  endproperty
  a_hold_sample: assert property (p_hold_sample)
    else $error("select moved during conversion");

  property p_start_after_settle;
    conv_start_q |-> $past(state_q) == ST_SETTLE ##1 !conv_start_q;
  endproperty
  a_start_after_settle: assert property (p_start_after_settle)
    else $error("conversion start not a pulse after settle");

  property p_last_slot;
    seq_end |=> (state_q == ST_IDLE) && !busy_q ##0 slot_q == last_slot;
  endproperty
  a_last_slot: assert property (p_last_slot)
    else $error("sequence did not stop at last slot");
endmodule // sequence_input_select

// File: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import seqsel_pkg::*;
  // ****************************************
  // Signals and design
  // ****************************************
  typedef struct packed {
    logic [31:0] word;
    logic [7:0] temp;
    logic [2:0] last;
  } row_t;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [ADDR_W-1:0] awaddr = 12'h000;
  logic awvalid = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic [ADDR_W-1:0] araddr = 12'h000;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic seq_trigger = 1'h0;
  logic sample_done = 1'h0;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out;
  logic [31:0] rdata_out;
  logic [SEL_W-1:0] mux_sel_out;
  logic temp_sel_out, conv_start_out, busy_out;
  logic [SLOT_W-1:0] slot_out;
  int bad_count = 0;
  int checks_done = 0;
  row_t rows [4];
  logic [1:0] resp;
  logic [31:0] rd;
  localparam int SETTLE = 2;

  always #12.5 clk_in = ~clk_in;

  sequence_input_select #(.SETTLE_CYCLES(SETTLE)) dut (
    .clk_in(clk_in), .rst_in(rst_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready_out),
    .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
    .wready_out(wready_out), .bresp_out(bresp_out),
    .bvalid_out(bvalid_out), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready_out),
    .rdata_out(rdata_out), .rresp_out(rresp_out),
    .rvalid_out(rvalid_out), .rready_in(rready),
    .seq_trigger_in(seq_trigger), .sample_done_in(sample_done),
    .mux_sel_out(mux_sel_out), .temp_sel_out(temp_sel_out),
    .conv_start_out(conv_start_out), .busy_out(busy_out),
    .slot_out(slot_out)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic tmo(input string nm);
    $display("[ERR] %s expected answer seen timeout", nm);
    bad_count++;
    stop_test();
  endtask

  // ****************************************
  // Register bus master
  // ****************************************
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clk_in);
      n++;
      if (awvalid && awready_out === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready_out === 1'h1) wvalid <= 1'h0;
      if (bvalid_out === 1'h1) begin
        r = bresp_out;
        bready <= 1'h0;
        break;
      end
      if (n > 100) tmo("write");
    end
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clk_in);
      n++;
      if (arvalid && arready_out === 1'h1) arvalid <= 1'h0;
      if (rvalid_out === 1'h1) begin
        d = rdata_out;
        r = rresp_out;
        rready <= 1'h0;
        break;
      end
      if (n > 100) tmo("read");
    end
  endtask

  // ****************************************
  // Sequencer run with per-slot checks
  // ****************************************
  task automatic run_seq(input row_t rw);
    logic [1:0] r;
    logic [2:0] e;
    int n;
    axi_wr(OFS_INPUT_SELECT, rw.word, 4'hF, r);
    axi_wr(OFS_SEQ_CONTROL, {21'h0, rw.last, rw.temp}, 4'hF, r);
    @(posedge clk_in) seq_trigger <= 1'h1;
    @(posedge clk_in) seq_trigger <= 1'h0;
    for (int s = 0; s <= int'(rw.last); s++) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (conv_start_out !== 1'h1 && n < 50);
      if (n >= 50) tmo("conv_start");
      chk("settle_cycles", SETTLE + 1, n);
      case (s)
        0: e = rw.word[2:0];
        1: e = rw.word[6:4];
        2: e = rw.word[10:8];
        3: e = rw.word[14:12];
        4: e = rw.word[18:16];
        5: e = rw.word[22:20];
        6: e = rw.word[26:24];
        default: e = rw.word[30:28];
      endcase
      chk("mux_sel", 32'(e), 32'(mux_sel_out));
      chk("temp_sel", {31'h0, rw.temp[s]}, {31'h0, temp_sel_out});
      chk("slot", 32'(s), {29'h0, slot_out});
      chk("busy", 32'h1, {31'h0, busy_out});
      sample_done <= 1'h1;
      @(posedge clk_in) sample_done <= 1'h0;
      chk("mux_hold", 32'(e), 32'(mux_sel_out));
      chk("start_pulse", 32'h0, 32'(conv_start_out));
    end
    @(posedge clk_in);
    chk("busy_end", 32'h0, {31'h0, busy_out});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rows[0] = '{32'h7654_3210, 8'h00, 3'h7};
    rows[1] = '{32'h0123_4567, 8'hA5, 3'h7};
    rows[2] = '{32'h3715_2640, 8'hFF, 3'h3};
    rows[3] = '{32'h0000_0001, 8'h00, 3'h0};
    repeat (3) @(posedge clk_in);
    rst_in <= 1'h0;
    axi_rd(OFS_INPUT_SELECT, rd, resp);
    chk("select_reset", INPUT_SELECT_RST, rd);
    axi_wr(OFS_INPUT_SELECT, 32'hFFFF_FFFF, 4'hF, resp);
    chk("wr_resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    axi_rd(OFS_INPUT_SELECT, rd, resp);
    chk("select_mask", 32'h7777_7777, rd);
    axi_wr(OFS_INPUT_SELECT, 32'h0000_0000, 4'h2, resp);
    axi_rd(OFS_INPUT_SELECT, rd, resp);
    chk("select_strb", 32'h7777_0077, rd);
    axi_wr(12'h100, 32'h1234_5678, 4'hF, resp);
    chk("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_rd(12'h100, rd, resp);
    chk("unmapped_rd", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("unmapped_data", 32'h0000_0000, rd);
    axi_wr(OFS_SEQ_STATUS, 32'hFFFF_FFFF, 4'hF, resp);
    chk("status_wr", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_rd(OFS_SEQ_STATUS, rd, resp);
    chk("status_idle", 32'h0000_0100, rd);
    foreach (rows[i]) begin
      run_seq(rows[i]);
    end
    axi_rd(OFS_INPUT_SELECT, rd, resp);
    chk("select_keep", 32'h0000_0001, rd);
    // Reset in mid-sequence clears both the run and the register
    @(posedge clk_in) seq_trigger <= 1'h1;
    @(posedge clk_in) seq_trigger <= 1'h0;
    // Sample done while settling must not end the run
    sample_done <= 1'h1;
    @(posedge clk_in) sample_done <= 1'h0;
    @(posedge clk_in) rst_in <= 1'h1;
    chk("done_refused", 32'h1, {31'h0, busy_out});
    repeat (2) @(posedge clk_in);
    chk("busy_rst", 32'h0, {31'h0, busy_out});
    chk("mux_rst", 32'h0, {29'h0, mux_sel_out});
    rst_in <= 1'h0;
    axi_rd(OFS_INPUT_SELECT, rd, resp);
    chk("select_rerst", INPUT_SELECT_RST, rd);
    stop_test();
  end
endmodule // testbench
